// ---- pad_mux_pkg.sv ----
`default_nettype none
package pad_mux_pkg;
  localparam int NPORT = 6;
  localparam int NPIN = 16;
  localparam int NPAD = NPORT * NPIN;
  localparam int NFUNC = 6;
  localparam int NSIG = 4;
  localparam int SLOT_W = 3;
  localparam int FLD_W = 4;
  localparam int MODES_PER_REG = 8;
  localparam int DATA_W = 32;

  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_F = 3'h5;

  localparam logic [2:0] FN_SER0 = 3'h0;
  localparam logic [2:0] FN_SER1 = 3'h1;
  localparam logic [2:0] FN_TW0 = 3'h2;
  localparam logic [2:0] FN_TW1 = 3'h3;
  localparam logic [2:0] FN_TIM0 = 3'h4;
  localparam logic [2:0] FN_TIM1 = 3'h5;

  // Positions: tx/mosi/scl/ch0, rx/miso/sda/ch1, cts/clk/ch2, rts/cs
  localparam logic [1:0] SIG_TX = 2'h0;
  localparam logic [1:0] SIG_RX = 2'h1;
  localparam logic [1:0] SIG_CTS = 2'h2;
  localparam logic [1:0] SIG_RTS = 2'h3;

  localparam logic [2:0] SLOT_0 = 3'h0;
  localparam logic [2:0] SLOT_1 = 3'h1;
  localparam logic [2:0] SLOT_2 = 3'h2;
  localparam logic [2:0] SLOT_3 = 3'h3;
  localparam logic [2:0] SLOT_4 = 3'h4;
  localparam logic [2:0] SLOT_5 = 3'h5;
  localparam logic [2:0] SLOT_6 = 3'h6;

  localparam logic [7:0] OFS_ROUTE = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_IRQ_EDGE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_SEL_LO = 8'h10;
  localparam logic [7:0] OFS_IRQ_SEL_HI = 8'h14;
  localparam logic [7:0] OFS_DATA = 8'h20;
  localparam logic [7:0] OFS_MODE = 8'h40;

  localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;
  localparam logic [NPIN-1:0] IRQ_GROUP_OK = 16'hFEFE;
  localparam logic [NPIN-1:0] PIN8_MASK = 16'h0100;
  localparam logic [NPIN-1:0] PRESENT_A = 16'h0044;
  localparam logic [NPIN-1:0] PRESENT_B = 16'h1800;
  localparam logic [NPIN-1:0] PRESENT_C = 16'hE203;
  localparam logic [NPIN-1:0] PRESENT_D = 16'h00FF;
  localparam logic [NPIN-1:0] PRESENT_E = 16'hFC07;
  localparam logic [NPIN-1:0] PRESENT_F = 16'h0C07;

  typedef enum logic [2:0] {
    MODE_DISABLED,
    MODE_IN_PU,
    MODE_IN_PD,
    MODE_IN_PU_FILT,
    MODE_IN_PD_FILT,
    MODE_OUTPUT
  } gpio_mode_e;

  // Valid bit, port, pin number
  typedef logic [7:0] pin_code_t;

  typedef struct packed {
    logic [NSIG-1:0] out;
    logic [NSIG-1:0] oe;
  } periph_drive_s;

  typedef struct packed {
    logic [NPAD-1:0] out;
    logic [NPAD-1:0] oe;
    logic [NPAD-1:0] pull_up;
    logic [NPAD-1:0] pull_dn;
  } pad_drive_s;
endpackage
`default_nettype wire

// ---- glitch_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module glitch_filter #(
  parameter int W = 8,
  parameter int DEPTH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [DEPTH-1:0] hist_q [W];
  logic [W-1:0] dout_q;

  if (DEPTH < 2 || W < 1) begin : g_bad
    $error("glitch_filter: DEPTH must be at least 2");
  end

  // Output moves only after DEPTH equal samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < W; i++) begin
        hist_q[i] <= '0;
      end
      dout_q <= '0;
    end else if (ce) begin
      for (int i = 0; i < W; i++) begin
        hist_q[i] <= {hist_q[i][DEPTH-2:0], din[i]};
        if (&hist_q[i]) begin
          dout_q[i] <= 1'b1;
        end else if (~|hist_q[i]) begin
          dout_q[i] <= 1'b0;
        end
      end
    end
  end

  assign dout = dout_q;
endmodule // glitch_filter
`default_nettype wire

// ---- pin_irq_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_irq_unit #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] src,
  input wire logic [W-1:0] rise_en,
  input wire logic [W-1:0] fall_en,
  input wire logic [W-1:0] mask,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] status,
  output logic irq
);
  logic [W-1:0] src_q;
  logic [W-1:0] status_q;
  logic [W-1:0] edge_v;
  logic [W-1:0] status_d;

  if (W < 1) begin : g_bad
    $error("pin_irq_unit: W must be positive");
  end

  assign edge_v = (src & ~src_q & rise_en) | (~src & src_q & fall_en);
  // Set wins over a clear in the same cycle
  assign status_d = (status_q & ~clr) | edge_v;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= '0;
      status_q <= '0;
    end else if (ce) begin
      src_q <= src;
      status_q <= status_d;
    end
  end

  assign status = status_q;
  assign irq = |(status_q & mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  status_set_a: assert property (
    ce |=> (status_q & $past(edge_v)) == $past(edge_v))
    else $error("pin edge did not set its status bit");

  read_clear_a: assert property (
    (ce && |clr && (clr & edge_v) == '0) |=>
      (status_q & $past(clr)) == '0)
    else $error("read did not clear status bits");
endmodule // pin_irq_unit
`default_nettype wire

// ---- pad_location_mux_and_pin_irq.sv ----
`timescale 1ns/1ps
`default_nettype none
module pad_location_mux_and_pin_irq
  import pad_mux_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int FILT_DEPTH = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPAD-1:0] pad_in,
  output pad_drive_s pad_drv,
  input wire periph_drive_s [NFUNC-1:0] periph_drv,
  output logic [NFUNC-1:0][NSIG-1:0] periph_in,
  output logic [1:0] flow_avail,
  output logic irq
);
  if (ADDR_W < 8 || FILT_DEPTH < 2) begin : g_bad
    $error("ADDR_W below 8 or FILT_DEPTH below 2");
  end

  // Location table, one fixed pad per function, signal and slot
  function automatic pin_code_t pc(
    input logic [2:0] port,
    input logic [3:0] pin
  );
    return {1'b1, port, pin};
  endfunction

  function automatic pin_code_t route_pin(
    input logic [2:0] f,
    input logic [1:0] s,
    input logic [2:0] l
  );
    pin_code_t r;
    r = '0;
    case (f)
      FN_SER0: begin
        case ({s, l})
          {SIG_TX, SLOT_0}: r = pc(PORT_E, 4'hA);
          {SIG_RX, SLOT_0}: r = pc(PORT_E, 4'hB);
          {SIG_CTS, SLOT_0}: r = pc(PORT_E, 4'hC);
          {SIG_RTS, SLOT_0}: r = pc(PORT_E, 4'hD);
          {SIG_TX, SLOT_3}: r = pc(PORT_E, 4'hD);
          {SIG_RX, SLOT_3}: r = pc(PORT_E, 4'hC);
          {SIG_CTS, SLOT_3}: r = pc(PORT_C, 4'hF);
          {SIG_RTS, SLOT_3}: r = pc(PORT_C, 4'hE);
          {SIG_TX, SLOT_5}: r = pc(PORT_C, 4'h0);
          {SIG_RX, SLOT_5}: r = pc(PORT_C, 4'h1);
          default: r = '0;
        endcase
      end
      FN_SER1: begin
        case ({s, l})
          {SIG_TX, SLOT_0}: r = pc(PORT_C, 4'h0);
          {SIG_RX, SLOT_0}: r = pc(PORT_C, 4'h1);
          {SIG_TX, SLOT_1}: r = pc(PORT_D, 4'h0);
          {SIG_RX, SLOT_1}: r = pc(PORT_D, 4'h1);
          {SIG_CTS, SLOT_1}: r = pc(PORT_D, 4'h2);
          {SIG_RTS, SLOT_1}: r = pc(PORT_D, 4'h3);
          {SIG_TX, SLOT_2}: r = pc(PORT_D, 4'h7);
          {SIG_RX, SLOT_2}: r = pc(PORT_D, 4'h6);
          {SIG_CTS, SLOT_2}: r = pc(PORT_F, 4'h0);
          {SIG_RTS, SLOT_2}: r = pc(PORT_F, 4'h1);
          default: r = '0;
        endcase
      end
      FN_TW0: begin
        case ({s, l})
          {SIG_TX, SLOT_1}: r = pc(PORT_D, 4'h7);
          {SIG_RX, SLOT_1}: r = pc(PORT_D, 4'h6);
          {SIG_TX, SLOT_4}: r = pc(PORT_C, 4'h1);
          {SIG_RX, SLOT_4}: r = pc(PORT_C, 4'h0);
          {SIG_TX, SLOT_5}: r = pc(PORT_F, 4'h1);
          {SIG_RX, SLOT_5}: r = pc(PORT_F, 4'h0);
          {SIG_TX, SLOT_6}: r = pc(PORT_E, 4'hD);
          {SIG_RX, SLOT_6}: r = pc(PORT_E, 4'hC);
          default: r = '0;
        endcase
      end
      FN_TW1: begin
        case ({s, l})
          {SIG_TX, SLOT_1}: r = pc(PORT_B, 4'hC);
          {SIG_RX, SLOT_1}: r = pc(PORT_B, 4'hB);
          {SIG_TX, SLOT_2}: r = pc(PORT_E, 4'h1);
          {SIG_RX, SLOT_2}: r = pc(PORT_E, 4'h0);
          default: r = '0;
        endcase
      end
      FN_TIM0: begin
        case ({s, l})
          {SIG_TX, SLOT_3}: r = pc(PORT_D, 4'h1);
          {SIG_RX, SLOT_3}: r = pc(PORT_D, 4'h2);
          {SIG_CTS, SLOT_3}: r = pc(PORT_D, 4'h3);
          {SIG_TX, SLOT_5}: r = pc(PORT_F, 4'h0);
          {SIG_RX, SLOT_5}: r = pc(PORT_F, 4'h1);
          {SIG_CTS, SLOT_5}: r = pc(PORT_F, 4'h2);
          default: r = '0;
        endcase
      end
      FN_TIM1: begin
        case ({s, l})
          {SIG_TX, SLOT_0}: r = pc(PORT_C, 4'hD);
          {SIG_RX, SLOT_0}: r = pc(PORT_C, 4'hE);
          {SIG_CTS, SLOT_0}: r = pc(PORT_C, 4'hF);
          {SIG_TX, SLOT_1}: r = pc(PORT_E, 4'hA);
          {SIG_RX, SLOT_1}: r = pc(PORT_E, 4'hB);
          {SIG_CTS, SLOT_1}: r = pc(PORT_E, 4'hC);
          {SIG_TX, SLOT_4}: r = pc(PORT_D, 4'h6);
          {SIG_RX, SLOT_4}: r = pc(PORT_D, 4'h7);
          {SIG_CTS, SLOT_4}: r = pc(PORT_C, 4'hD);
          default: r = '0;
        endcase
      end
      default: r = '0;
    endcase
    return r;
  endfunction

  function automatic logic [NPIN-1:0] present(input logic [2:0] p);
    logic [NPIN-1:0] m;
    case (p)
      PORT_A: m = PRESENT_A;
      PORT_B: m = PRESENT_B;
      PORT_C: m = PRESENT_C;
      PORT_D: m = PRESENT_D;
      PORT_E: m = PRESENT_E;
      PORT_F: m = PRESENT_F;
      default: m = '0;
    endcase
    return m & ~PIN8_MASK;
  endfunction

  function automatic gpio_mode_e mode_of(input logic [2:0] c);
    gpio_mode_e m;
    if (c > MODE_OUTPUT) begin
      m = MODE_DISABLED;
    end else begin
      m = gpio_mode_e'(c);
    end
    return m;
  endfunction

  // Valid bit and port of a data register
  function automatic logic [3:0] data_sel(input logic [7:0] o);
    logic [7:0] r;
    r = o - OFS_DATA;
    return {(o >= OFS_DATA) && (r[7:2] < 6'(NPORT)), r[4:2]};
  endfunction

  // Valid bit, port and half of a mode register
  function automatic logic [4:0] mode_sel(input logic [7:0] o);
    logic [7:0] r;
    r = o - OFS_MODE;
    return {(o >= OFS_MODE) && (r[7:3] < 5'(NPORT)), r[5:2]};
  endfunction

  logic [7:0] off;
  logic setup;
  logic acc;
  logic wr;
  logic [3:0] dsel;
  logic [4:0] msel;
  logic [DATA_W-1:0] rd_d;
  logic [DATA_W-1:0] rdata_q;
  logic err_d;
  logic err_q;
  logic [NFUNC-1:0][FLD_W-1:0] route_q;
  logic [NPIN-1:0] mask_q;
  logic [DATA_W-1:0] edge_q;
  logic [NPIN-1:0][FLD_W-1:0] sel_q;
  gpio_mode_e mode_q [NPAD];
  logic [NPAD-1:0] dout_q;
  logic [NPAD-1:0] present_v;
  logic [NPAD-1:0] claim;
  logic [NPAD-1:0] c_out;
  logic [NPAD-1:0] c_oe;
  logic [NPAD-1:0] filt_in;
  logic [NPAD-1:0] gpio_in;
  logic [NPAD-1:0] dis_v;
  logic [NFUNC-1:0][NSIG-1:0] pin_d;
  pin_code_t code;
  pad_drive_s pad_d;
  pad_drive_s pad_q;
  logic [NFUNC-1:0][NSIG-1:0] periph_in_q;
  logic [1:0] flow_d;
  logic [1:0] flow_q;
  pin_code_t cts_first;
  pin_code_t cts_second;
  logic [NPIN-1:0] sel_en_v;
  logic [NPIN-1:0] irq_src;
  logic [NPIN-1:0] irq_clr;
  logic [NPIN-1:0] irq_status;
  logic started_q;

  assign off = {paddr[7:2], 2'h0};
  assign setup = psel && !penable;
  assign acc = psel && penable && ce;
  assign wr = acc && pwrite;
  assign dsel = data_sel(off);
  assign msel = mode_sel(off);
  assign pready = ce;
  assign prdata = rdata_q;
  assign pslverr = err_q;

  always_comb begin
    rd_d = '0;
    err_d = 1'b0;
    if (dsel[3]) begin
      rd_d = {gpio_in[{dsel[2:0], 4'h0} +: NPIN],
              dout_q[{dsel[2:0], 4'h0} +: NPIN]};
    end else if (msel[4]) begin
      for (int k = 0; k < MODES_PER_REG; k++) begin
        rd_d[k*FLD_W +: 3] = mode_q[{msel[3:0], 3'(k)}];
      end
    end else begin
      case (off)
        OFS_ROUTE: rd_d = DATA_W'(route_q);
        OFS_IRQ_STAT: rd_d = DATA_W'(irq_status);
        OFS_IRQ_MASK: rd_d = DATA_W'(mask_q);
        OFS_IRQ_EDGE: rd_d = edge_q;
        OFS_IRQ_SEL_LO: rd_d = sel_q[7:0];
        OFS_IRQ_SEL_HI: rd_d = sel_q[15:8];
        default: err_d = 1'b1;
      endcase
    end
  end

  // Read data and error taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= REG_RST;
      err_q <= 1'b0;
    end else if (ce && setup) begin
      rdata_q <= rd_d;
      err_q <= err_d;
    end
  end

  // Clears only the bits that this read returned
  assign irq_clr = (acc && !pwrite && off == OFS_IRQ_STAT) ?
                   rdata_q[NPIN-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= '0;
      mask_q <= '0;
      edge_q <= REG_RST;
      sel_q <= '0;
    end else if (wr) begin
      case (off)
        OFS_ROUTE: route_q <= pwdata[NFUNC*FLD_W-1:0];
        OFS_IRQ_MASK: mask_q <= pwdata[NPIN-1:0] & IRQ_GROUP_OK;
        OFS_IRQ_EDGE: edge_q <= pwdata & {IRQ_GROUP_OK, IRQ_GROUP_OK};
        OFS_IRQ_SEL_LO, OFS_IRQ_SEL_HI: begin
          for (int g = 0; g < NPIN; g++) begin
            if (IRQ_GROUP_OK[g] && off[2] == g[3]) begin
              sel_q[g] <= pwdata[g[2:0]*FLD_W +: FLD_W];
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NPAD; i++) begin
        mode_q[i] <= MODE_DISABLED;
      end
    end else if (wr && msel[4]) begin
      for (int k = 0; k < MODES_PER_REG; k++) begin
        if (present_v[{msel[3:0], 3'(k)}]) begin
          mode_q[{msel[3:0], 3'(k)}] <=
            mode_of(pwdata[k*FLD_W +: 3]);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_q <= '0;
    end else if (wr && dsel[3]) begin
      dout_q[{dsel[2:0], 4'h0} +: NPIN] <=
        pwdata[NPIN-1:0] & present(dsel[2:0]);
    end
  end

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      present_v[p*NPIN +: NPIN] = present(3'(p));
    end
  end

  // Lower function index wins a pad claimed twice
  always_comb begin
    claim = '0;
    c_out = '0;
    c_oe = '0;
    pin_d = '0;
    code = '0;
    for (int f = NFUNC - 1; f >= 0; f--) begin
      for (int s = 0; s < NSIG; s++) begin
        code = route_pin(3'(f), 2'(s), route_q[f][SLOT_W-1:0]);
        if (route_q[f][FLD_W-1] && code[7]) begin
          claim[code[6:0]] = 1'b1;
          c_out[code[6:0]] = periph_drv[f].out[s];
          c_oe[code[6:0]] = periph_drv[f].oe[s];
          pin_d[f][s] = pad_in[code[6:0]];
        end
      end
    end
  end

  // Handshake lines exist only where both pads are provided
  always_comb begin
    cts_first = route_pin(FN_SER0, SIG_CTS, route_q[FN_SER0][SLOT_W-1:0]);
    cts_second = route_pin(FN_SER1, SIG_CTS, route_q[FN_SER1][SLOT_W-1:0]);
    flow_d[0] = route_q[FN_SER0][FLD_W-1] && cts_first[7];
    flow_d[1] = route_q[FN_SER1][FLD_W-1] && cts_second[7];
  end

  always_comb begin
    pad_d = '0;
    dis_v = '0;
    for (int i = 0; i < NPAD; i++) begin
      if (present_v[i] && claim[i]) begin
        pad_d.out[i] = c_out[i];
        pad_d.oe[i] = c_oe[i];
      end else if (present_v[i]) begin
        unique case (mode_q[i])
          MODE_OUTPUT: begin
            pad_d.out[i] = dout_q[i];
            pad_d.oe[i] = 1'b1;
          end
          MODE_IN_PU, MODE_IN_PU_FILT: pad_d.pull_up[i] = 1'b1;
          MODE_IN_PD, MODE_IN_PD_FILT: pad_d.pull_dn[i] = 1'b1;
          MODE_DISABLED: dis_v[i] = 1'b1;
        endcase
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NPAD; i++) begin
      if (mode_q[i] == MODE_IN_PU_FILT || mode_q[i] == MODE_IN_PD_FILT) begin
        gpio_in[i] = filt_in[i];
      end else begin
        gpio_in[i] = pad_in[i] && present_v[i] &&
                     mode_q[i] != MODE_DISABLED;
      end
    end
  end

  // One port per pin-number group drives its interrupt line
  always_comb begin
    for (int g = 0; g < NPIN; g++) begin
      sel_en_v[g] = sel_q[g][FLD_W-1] && IRQ_GROUP_OK[g] &&
                    sel_q[g][2:0] <= PORT_F;
      irq_src[g] = sel_en_v[g] &&
                   gpio_in[{sel_q[g][2:0], 4'(g)}];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_q <= '0;
      periph_in_q <= '0;
      flow_q <= '0;
      started_q <= 1'b0;
    end else if (ce) begin
      pad_q <= pad_d;
      periph_in_q <= pin_d;
      flow_q <= flow_d;
      started_q <= 1'b1;
    end
  end

  assign pad_drv = pad_q;
  assign periph_in = periph_in_q;
  assign flow_avail = flow_q;

  glitch_filter #(
    .W(NPAD),
    .DEPTH(FILT_DEPTH)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(pad_in),
    .dout(filt_in)
  );

  pin_irq_unit #(
    .W(NPIN)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .src(irq_src),
    .rise_en(edge_q[NPIN-1:0]),
    .fall_en(edge_q[DATA_W-1:NPIN]),
    .mask(mask_q),
    .clr(irq_clr),
    .status(irq_status),
    .irq(irq)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  reset_tristate_a: assert property (
    !started_q |-> (pad_q.oe == '0 && pad_q.pull_up == '0 &&
                    pad_q.pull_dn == '0))
    else $error("pad not tristated after reset");

  absent_quiet_a: assert property (
    ((pad_q.oe | pad_q.pull_up | pad_q.pull_dn) & ~present_v) == '0)
    else $error("absent pin is driven");

  disabled_float_a: assert property (
    ce |=> ((pad_q.oe | pad_q.pull_up | pad_q.pull_dn) &
            $past(dis_v)) == '0)
    else $error("disabled pin is not tristated");

  claim_follow_a: assert property (
    ce |=> (((pad_q.out ^ $past(c_out)) | (pad_q.oe ^ $past(c_oe))) &
            $past(claim)) == '0)
    else $error("claimed pad does not follow its function");

  flow_first_a: assert property (
    (ce && route_q[FN_SER0][SLOT_W-1:0] == SLOT_5) |=> !flow_avail[0])
    else $error("flow control offered at slot 5");

  flow_second_a: assert property (
    (ce && route_q[FN_SER1][SLOT_W-1:0] == SLOT_0) |=> !flow_avail[1])
    else $error("flow control offered at slot 0");

  pin0_quiet_a: assert property (
    !irq_status[0])
    else $error("pin 0 group raised an interrupt");

  pin8_quiet_a: assert property (
    !irq_status[8])
    else $error("pin 8 group raised an interrupt");

  unselected_quiet_a: assert property (
    $past(ce, 2) |-> (irq_status & ~$past(irq_status) &
                      ~$past(sel_en_v) & ~$past(sel_en_v, 2)) == '0)
    else $error("unselected group raised its status");
endmodule // pad_location_mux_and_pin_irq
`default_nettype wire

// ---- pad_board_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pad_board_model
  import pad_mux_pkg::*;
(
  input wire logic pclk,
  input wire pad_drive_s pad_drv,
  input wire logic [NPAD-1:0] ext_val,
  input wire logic [NPAD-1:0] ext_en,
  output logic [NPAD-1:0] pad_in
);
  // Floating pads wander every cycle
  logic [NPAD-1:0] float_q = '0;

  always_ff @(posedge pclk) begin
    float_q <= ~float_q;
  end

  // Pad drive wins, then board driver, then pulls
  always_comb begin
    pad_in = (pad_drv.oe & pad_drv.out) | (~pad_drv.oe & ext_en & ext_val)
      | (~pad_drv.oe & ~ext_en
      & (pad_drv.pull_up | (~pad_drv.pull_dn & float_q)));
  end
endmodule // pad_board_model
`default_nettype wire

// ---- pad_location_mux_and_pin_irq_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pad_location_mux_and_pin_irq_tb;
  import pad_mux_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic ce = 1'b1;
  logic pwrite = 1'b0, pready, pslverr, irq, rerr, b;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [NPAD-1:0] pad_in, ext_val = '0, ext_en = '0, exp;
  pad_drive_s pad_drv;
  periph_drive_s [NFUNC-1:0] periph_drv = '0, drv;
  logic [NFUNC-1:0][NSIG-1:0] periph_in;
  logic [1:0] flow_avail, fa;
  logic [19:0] e;
  int fail_count = 0, checked = 0;
  localparam logic [NPAD-1:0] pin_b11 = 96'h1 << 27;
  localparam logic [NPAD-1:0] pin_e11 = 96'h1 << 75;
  // Function, slot, signal, pad (port digit, pin digit)
  localparam logic [19:0] TBL [47] = '{
    20'h0004A, 20'h0014B, 20'h0024C, 20'h0034D, 20'h0304D, 20'h0314C,
    20'h0322F, 20'h0332E, 20'h05020, 20'h05121, 20'h10020, 20'h10121,
    20'h11030, 20'h11131, 20'h11232, 20'h11333, 20'h12037, 20'h12136,
    20'h12250, 20'h12351, 20'h21037, 20'h21136, 20'h24021, 20'h24120,
    20'h25051, 20'h25150, 20'h2604D, 20'h2614C, 20'h3101C, 20'h3111B,
    20'h32041, 20'h32140, 20'h43031, 20'h43132, 20'h43233, 20'h45050,
    20'h45151, 20'h45252, 20'h5002D, 20'h5012E, 20'h5022F, 20'h5104A,
    20'h5114B, 20'h5124C, 20'h54036, 20'h54137, 20'h5422D};

  initial begin
    forever #10 pclk = ~pclk;
  end

  pad_location_mux_and_pin_irq #(.ADDR_W(8), .FILT_DEPTH(3)) uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_drv(pad_drv), .periph_drv(periph_drv), .periph_in(periph_in),
    .flow_avail(flow_avail), .irq(irq));

  pad_board_model board (.pclk(pclk), .pad_drv(pad_drv),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

  task automatic chk(input logic [NPAD-1:0] seen, input logic [NPAD-1:0] want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stop_test;
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fail_count++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h67d6));
    tick(4);
    chk(pad_drv.oe | pad_drv.out | pad_drv.pull_up | pad_drv.pull_dn,
      '0);
    chk({periph_in, flow_avail, irq}, '0);
    tick(4);
    presetn <= 1'b1;
    apb(1'b0, 8'h58, '0);
    chk(rdat, '0);
    apb(1'b0, 8'h18, '0);
    chk({rerr, rdat}, 33'h1_0000_0000);
    // Each routed signal lands on its own pad only
    foreach (TBL[i]) begin
      e = TBL[i];
      drv = '0;
      drv[e[18:16]].out[e[9:8]] = 1'b1;
      drv[e[18:16]].oe[e[9:8]] = 1'b1;
      exp = 96'h1 << e[7:0];
      fa = '0;
      if (e[18:16] < 2 && e[14:12] != (e[16] ? 3'h0 : 3'h5)) fa[e[16]] = 1'b1;
      apb(1'b1, OFS_ROUTE, 32'({1'b1, e[14:12]}) << (4 * e[18:16]));
      periph_drv <= drv;
      tick(3);
      chk(pad_drv.oe, exp);
      chk(pad_drv.out, exp);
      chk(flow_avail, fa);
      b = 1'($urandom);
      periph_drv <= '0;
      ext_val <= {NPAD{b}};
      ext_en <= exp;
      tick(3);
      chk(periph_in[e[18:16]][e[9:8]], b);
      ext_en <= '0;
    end
    apb(1'b1, OFS_ROUTE, '0);
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, 8'h58, 32'(m) << 12);
      apb(1'b1, 8'h2C, 32'h8);
      tick(7);
      chk({pad_drv.oe[51], pad_drv.pull_up[51], pad_drv.pull_dn[51]},
        {m == 5, m == 1 || m == 3, m == 2 || m == 4});
      apb(1'b0, 8'h2C, '0);
      if (m < 5) chk(rdat[19], m == 1 || m == 3);
    end
    apb(1'b1, 8'h58, 32'h7000);
    apb(1'b0, 8'h58, '0);
    chk(rdat, '0);
    apb(1'b1, 8'h40, 32'h5);
    apb(1'b0, 8'h40, '0);
    chk(rdat, '0);
    chk(pad_drv.oe[0], 1'b0);
    // Pin 11 group: port B selected, port E ignored
    apb(1'b1, 8'h4C, 32'h2000);
    apb(1'b1, 8'h64, 32'h2000);
    apb(1'b1, OFS_IRQ_EDGE, 32'h800);
    apb(1'b1, OFS_IRQ_MASK, 32'h800);
    apb(1'b1, OFS_IRQ_SEL_HI, 32'h9000);
    ext_val <= '0;
    ext_en <= pin_b11 | pin_e11;
    tick(4);
    apb(1'b0, OFS_IRQ_STAT, '0);
    ext_val <= pin_e11;
    tick(6);
    chk(irq, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, '0);
    chk(rdat, '0);
    ext_val <= pin_b11 | pin_e11;
    tick(6);
    chk(irq, 1'b1);
    apb(1'b0, OFS_IRQ_STAT, '0);
    chk(rdat, 32'h800);
    tick(1);
    chk(irq, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, '0);
    ext_val <= pin_e11;
    tick(4);
    ext_val <= pin_b11 | pin_e11;
    tick(6);
    chk(irq, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, '0);
    chk(rdat, 32'h800);
    apb(1'b1, OFS_IRQ_MASK, 32'hFFFF);
    apb(1'b0, OFS_IRQ_MASK, '0);
    chk(rdat, 32'hFEFE);
    apb(1'b1, OFS_IRQ_EDGE, 32'hFFFF_FFFF);
    apb(1'b0, OFS_IRQ_EDGE, '0);
    chk(rdat, 32'hFEFE_FEFE);
    apb(1'b1, OFS_IRQ_SEL_LO, 32'hB);
    apb(1'b0, OFS_IRQ_SEL_LO, '0);
    chk(rdat, '0);
    // Frozen state, held edge lands once enabled
    ce <= 1'b0;
    ext_val <= '0;
    tick(4);
    chk({pready, irq}, 2'h0);
    ce <= 1'b1;
    tick(4);
    chk({pready, irq}, 2'h3);
    apb(1'b0, OFS_IRQ_STAT, '0);
    chk(rdat, 32'h800);
    stop_test();
  end
endmodule // pad_location_mux_and_pin_irq_tb
`default_nettype wire
